//--- inc/irq_ctrl_params.svh
// constants for the three-source interrupt controller
`ifndef IRQ_CTRL_PARAMS_SVH
`define IRQ_CTRL_PARAMS_SVH
`define IRQ_CTRL_ADDR       7'h0B
`define IRQ_CTRL_RESET      8'h00
`define BIT_GLOBAL_EN       0
`define BIT_EXT_EN          1
`define BIT_TIMER_EN        2
`define BIT_CONV_EN         3
`define BIT_EXT_FLAG        4
`define BIT_TIMER_FLAG      5
`define BIT_CONV_FLAG       6
`define BIT_TEST            7
`define VEC_EXT             12'h004
`define VEC_TIMER           12'h008
`define VEC_CONV            12'h00C
`endif

//--- inc/irq_ctrl_pkg.sv
// types for the three-source interrupt controller
package irq_ctrl_pkg;
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [6:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic        valid;
    logic [11:0] vector;
  } irq_call_t;
endpackage

//--- design/irq_sync.sv
// two-flop synchroniser with falling-edge detect
`timescale 1ns/1ps
module irq_sync (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic reset,
  // pin in, edge out
  input  wire logic pin_n,
  output logic      fall_ff
);
  logic meta_ff, sync_ff, last_ff;
  logic nxt_meta, nxt_sync, nxt_last, nxt_fall;

  // next-state: only sync_ff reads meta_ff
  always_comb begin
    nxt_meta = pin_n;
    nxt_sync = meta_ff;
    nxt_last = sync_ff;
    nxt_fall = last_ff & ~sync_ff;
  end

  // registers; pin idles high
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      meta_ff <= 1'b1;
      sync_ff <= 1'b1;
      last_ff <= 1'b1;
      fall_ff <= 1'b0;
    end else begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
      last_ff <= nxt_last;
      fall_ff <= nxt_fall;
    end
  end
endmodule // irq_sync

//--- design/irq_ctrl.sv
// three-source interrupt controller with control register
`timescale 1ns/1ps
`include "irq_ctrl_params.svh"
module irq_ctrl
  import irq_ctrl_pkg::*;
(
  // clock and reset
  input  wire logic      ref_clk,
  input  wire logic      reset,
  // data-memory register port
  input  wire reg_req_t  reg_req,
  output logic [7:0]     rdata_ff,
  // event sources
  input  wire logic      ext_irq_n,
  input  wire logic      timer_ovf,
  input  wire logic      conv_done,
  // sequencer side
  input  wire logic      late_phase_tick,
  input  wire logic      stack_full,
  input  wire logic      return_with_enable,
  output irq_call_t      call_ff,
  output logic           wake_ff
);
  // ************************************************************
  // external pin synchroniser
  // ************************************************************
  logic ext_fall;

  irq_sync u_sync (
    .ref_clk (ref_clk),
    .reset   (reset),
    .pin_n   (ext_irq_n),
    .fall_ff (ext_fall)
  );

  // ************************************************************
  // control register and arbitration
  // ************************************************************
  logic [7:0] ctrl_ff, nxt_ctrl;
  logic [7:0] nxt_rdata;
  irq_call_t  nxt_call;
  logic       nxt_wake;
  logic       wr_hit, rd_hit;
  logic [2:0] pend;
  logic [2:0] raw_pend;

  assign wr_hit = reg_req.wr && (reg_req.addr == `IRQ_CTRL_ADDR);
  assign rd_hit = reg_req.rd && (reg_req.addr == `IRQ_CTRL_ADDR);

  // flags already set, gated by their enables
  assign raw_pend = ctrl_ff[`BIT_CONV_FLAG:`BIT_EXT_FLAG]
                  & ctrl_ff[`BIT_CONV_EN:`BIT_EXT_EN];

  // global gate and stack gate
  assign pend = raw_pend & {3{ctrl_ff[`BIT_GLOBAL_EN]}}
              & {3{~stack_full}};

  // next-state of register, call and wake
  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_call = '0;
    nxt_wake = 1'b0;
    // software write; bit 7 kept zero
    if (wr_hit) begin
      nxt_ctrl = {1'b0, reg_req.wdata[6:0]};
    end
    // return with enable sets global, plain return does nothing
    if (return_with_enable) begin
      nxt_ctrl[`BIT_GLOBAL_EN] = 1'b1;
    end
    // acknowledge only at a late-phase tick, fixed priority
    if (late_phase_tick) begin
      if (pend[0]) begin
        nxt_call = '{valid: 1'b1, vector: `VEC_EXT};
        nxt_ctrl[`BIT_EXT_FLAG]  = 1'b0;
        nxt_ctrl[`BIT_GLOBAL_EN] = 1'b0;
      end else if (pend[1]) begin
        nxt_call = '{valid: 1'b1, vector: `VEC_TIMER};
        nxt_ctrl[`BIT_TIMER_FLAG] = 1'b0;
        nxt_ctrl[`BIT_GLOBAL_EN]  = 1'b0;
      end else if (pend[2]) begin
        nxt_call = '{valid: 1'b1, vector: `VEC_CONV};
        nxt_ctrl[`BIT_CONV_FLAG]  = 1'b0;
        nxt_ctrl[`BIT_GLOBAL_EN]  = 1'b0;
      end
    end
    // hardware sets win over any clear
    if (ext_fall) begin
      nxt_ctrl[`BIT_EXT_FLAG] = 1'b1;
    end
    if (timer_ovf) begin
      nxt_ctrl[`BIT_TIMER_FLAG] = 1'b1;
    end
    if (conv_done) begin
      nxt_ctrl[`BIT_CONV_FLAG] = 1'b1;
    end
    // any event wakes the halted core
    nxt_wake = ext_fall | timer_ovf | conv_done;
    nxt_rdata = rd_hit ? ctrl_ff : 8'h00;
  end

  // registers
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ctrl_ff  <= `IRQ_CTRL_RESET;
      rdata_ff <= 8'h00;
      call_ff  <= '0;
      wake_ff  <= 1'b0;
    end else begin
      ctrl_ff  <= nxt_ctrl;
      rdata_ff <= nxt_rdata;
      call_ff  <= nxt_call;
      wake_ff  <= nxt_wake;
    end
  end

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  sequence s_ext_ack;
    late_phase_tick && pend[0];
  endsequence

  a_ext_vector: assert property (s_ext_ack |=> call_ff.valid
      && call_ff.vector == `VEC_EXT && !ctrl_ff[`BIT_GLOBAL_EN])
    else $error("external ack wrong");
  a_stack_block: assert property (stack_full && !return_with_enable
      |=> !call_ff.valid)
    else $error("ack while stack full");
  a_tick_only: assert property (!late_phase_tick |=> !call_ff.valid)
    else $error("ack outside tick");
  a_global_mask: assert property (!ctrl_ff[`BIT_GLOBAL_EN]
      |=> !call_ff.valid)
    else $error("ack with global off");
  a_timer_prio: assert property (late_phase_tick && pend[1] && !pend[0]
      |=> call_ff.vector == `VEC_TIMER)
    else $error("timer priority wrong");
  a_conv_prio: assert property (late_phase_tick && pend == 3'b100
      && !conv_done |=> call_ff.vector == `VEC_CONV
      && !ctrl_ff[`BIT_CONV_FLAG])
    else $error("conversion ack wrong");
  a_ext_set: assert property (ext_fall |=> ctrl_ff[`BIT_EXT_FLAG])
    else $error("external flag not set");
  a_flag_hold: assert property (ctrl_ff[`BIT_TIMER_FLAG] && !wr_hit
      && !(late_phase_tick && pend[1]) |=> ctrl_ff[`BIT_TIMER_FLAG])
    else $error("timer flag lost");
  a_return_with_enable_set: assert property (return_with_enable && !late_phase_tick
      |=> ctrl_ff[`BIT_GLOBAL_EN])
    else $error("return did not enable");
  a_test_zero: assert property (ctrl_ff[`BIT_TEST] == 1'b0)
    else $error("test bit set");
  a_read_back: assert property (rd_hit |=> rdata_ff == $past(ctrl_ff))
    else $error("read data wrong");

  // ************************************************************
  // event capture, wake, single-call, full-stack and register write checks
  // ************************************************************
  // timer overflow seen by the register
  sequence s_timer_evt;
    timer_ovf;
  endsequence

  // conversion end seen by the register
  sequence s_conv_evt;
    conv_done;
  endsequence

  // any of the three sources fires
  sequence s_any_evt;
    ext_fall || timer_ovf || conv_done;
  endsequence

  // a write with nothing else acting on the register
  sequence s_quiet_write;
    wr_hit && !late_phase_tick && !return_with_enable && !ext_fall
      && !timer_ovf && !conv_done && !reg_req.wdata[`BIT_TEST];
  endsequence

  // flags set by hardware, also over a same-cycle clear
  a_timer_set: assert property (s_timer_evt
      |=> ctrl_ff[`BIT_TIMER_FLAG])
    else $error("timer flag not set");
  a_conv_set: assert property (s_conv_evt
      |=> ctrl_ff[`BIT_CONV_FLAG])
    else $error("conversion flag not set");

  // every source event leaves a wake pulse
  a_wake_any: assert property (s_any_evt |=> wake_ff)
    else $error("wake pulse missing");

  // one call per service, never two in a row
  a_call_single: assert property (call_ff.valid |=> !call_ff.valid)
    else $error("back-to-back calls");

  // a request under a full stack stays pending
  a_full_pending: assert property (stack_full && !wr_hit
      && ctrl_ff[`BIT_TIMER_FLAG] |=> ctrl_ff[`BIT_TIMER_FLAG])
    else $error("pending lost under full stack");

  // plain software write lands as written
  a_write_lands: assert property (s_quiet_write
      |=> ctrl_ff == $past(reg_req.wdata))
    else $error("write did not land");
endmodule // irq_ctrl

//--- bench/seq_model.sv
// sequencer stand-in: acknowledge ticks and stack level
`timescale 1ns/1ps
module seq_model (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic reset,
  // stack hold asked for by a scenario
  input  wire logic hold,
  // sequencer signals
  output logic      late_phase_tick,
  output logic      stack_full
);
  logic [1:0] cnt_ff = 2'h0;
  logic       tick_ff = 1'b0;
  // tick every fourth cycle, moved on the falling edge
  always @(negedge ref_clk) begin
    cnt_ff <= reset ? 2'h0 : cnt_ff + 2'h1;
    tick_ff <= (cnt_ff == 2'h3) && !reset;
  end
  assign late_phase_tick = tick_ff;
  // no nested calls, so the stack fills only on request
  assign stack_full = hold;
endmodule // seq_model

//--- bench/tb.sv
// self-checking bench for the interrupt controller
`timescale 1ns/1ps
module tb;
  import irq_ctrl_pkg::*;
  logic ref_clk = 1'b0, reset = 1'b1, ext_n = 1'b1, tovf = 1'b0;
  logic cdone = 1'b0, rwe = 1'b0, hold = 1'b0, tick, full, wake_ff;
  logic [7:0] rdata_ff;
  reg_req_t   reg_req = '0;
  irq_call_t  call_ff;
  int failures = 0, tests_run = 0;
  always #2 ref_clk = ~ref_clk;
  irq_ctrl i_irq_ctrl (.ref_clk(ref_clk), .reset(reset),
    .reg_req(reg_req), .rdata_ff(rdata_ff), .ext_irq_n(ext_n),
    .timer_ovf(tovf), .conv_done(cdone), .late_phase_tick(tick),
    .stack_full(full), .return_with_enable(rwe), .call_ff(call_ff),
    .wake_ff(wake_ff));
  seq_model i_seq_model (.ref_clk(ref_clk), .reset(reset),
    .hold(hold), .late_phase_tick(tick), .stack_full(full));
  task automatic chk(input logic [11:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] v);
    @(negedge ref_clk) reg_req = '{1'b1, 1'b0, a, {1'b0, v[6:0]}};
    @(negedge ref_clk) reg_req = '0;
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] v);
    @(negedge ref_clk) reg_req = '{1'b0, 1'b1, a, 8'h00};
    @(negedge ref_clk) reg_req = '0;
    chk(rdata_ff, v);
  endtask
  task automatic wait_call(input logic [11:0] v);
    int n = 0;
    while (call_ff.valid !== 1'b1 && n < 20) begin
      @(negedge ref_clk);
      n++;
    end
    chk(call_ff.valid ? call_ff.vector : 12'hFFF, v);
    @(negedge ref_clk);
  endtask
  task automatic no_call;
    int hits = 0;
    repeat (12) @(negedge ref_clk) hits += (call_ff.valid !== 1'b0);
    chk(hits, 0);
  endtask
  task automatic pulse_timer;
    @(negedge ref_clk) tovf = 1'b1;
    @(negedge ref_clk) tovf = 1'b0;
    chk(wake_ff, 1'b1);
  endtask
  // register access, enables and unmapped address
  task automatic t_regs;
    rd(7'h0B, 8'h00);
    wr(7'h0B, 8'h0E);
    rd(7'h0B, 8'h0E);
    rd(7'h0C, 8'h00);
  endtask
  // three sources pending, served in priority order
  task automatic t_priority;
    int w = 0;
    pulse_timer();
    @(negedge ref_clk) cdone = 1'b1;
    @(negedge ref_clk) cdone = 1'b0;
    chk(wake_ff, 1'b1);
    ext_n = 1'b0;
    repeat (8) @(negedge ref_clk) w += wake_ff;
    chk(w, 1);
    rd(7'h0B, 8'h7E);
    wr(7'h0B, 8'h7F);
    wait_call(12'h004);
    rd(7'h0B, 8'h6E);
    no_call();
    @(negedge ref_clk) rwe = 1'b1;
    @(negedge ref_clk) rwe = 1'b0;
    wait_call(12'h008);
    rd(7'h0B, 8'h4E);
    @(negedge ref_clk) rwe = 1'b1;
    @(negedge ref_clk) rwe = 1'b0;
    wait_call(12'h00C);
    rd(7'h0B, 8'h0E);
    ext_n = 1'b1;
  endtask
  // full stack holds the request until room returns
  task automatic t_stack;
    hold = 1'b1;
    wr(7'h0B, 8'h05);
    pulse_timer();
    no_call();
    rd(7'h0B, 8'h25);
    hold = 1'b0;
    wait_call(12'h008);
  endtask
  // global enable low masks a pending flag; software clears it
  task automatic t_mask;
    wr(7'h0B, 8'h04);
    pulse_timer();
    no_call();
    rd(7'h0B, 8'h24);
    wr(7'h0B, 8'h00);
    rd(7'h0B, 8'h00);
  endtask
  // reset in mid-run clears register and outputs
  task automatic t_reset;
    wr(7'h0B, 8'h0E);
    pulse_timer();
    rd(7'h0B, 8'h2E);
    @(negedge ref_clk) reset = 1'b1;
    repeat (12) @(negedge ref_clk);
    reset = 1'b0;
    rd(7'h0B, 8'h00);
    no_call();
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // watchdog against a hang
  initial begin
    #20000;
    failures++;
    end_of_test();
  end
  initial begin
    repeat (12) @(negedge ref_clk);
    reset = 1'b0;
    t_regs();
    t_priority();
    t_stack();
    t_mask();
    t_reset();
    end_of_test();
  end
endmodule // tb
